/* verilog/regulator_ctrl_defines.svh */
// offsets, field positions, reset values and voltage coding for the regulator slice
// assumes 32-bit APB words; offsets are word indices (byte address = 4 x index)
`ifndef REGULATOR_CTRL_DEFINES_SVH
`define REGULATOR_CTRL_DEFINES_SVH

// ==========================================
// register indices
`define RC_IDX_A_SEQ 8'hc9
`define RC_IDX_A_LP 8'hca
`define RC_IDX_B_CTRL 8'hcb
`define RC_IDX_INT_STATUS 8'hd0
`define RC_IDX_INT_CLEAR 8'hd1
`define RC_IDX_INT_ENABLE 8'hd2
`define RC_IDX_HIB_CTRL 8'hd3
`define RC_IDX_OUT_STATUS 8'hd4

// ==========================================
// field positions
`define RC_A_FAULT_MSB 15
`define RC_A_FAULT_LSB 14
`define RC_A_START_MSB 13
`define RC_A_START_LSB 10
`define RC_A_STOP_MSB 9
`define RC_A_STOP_LSB 6
`define RC_A_HIB_BEH_MSB 13
`define RC_A_HIB_BEH_LSB 12
`define RC_A_HIB_TRIG_MSB 9
`define RC_A_HIB_TRIG_LSB 8
`define RC_VOLT_MSB 4
`define RC_VOLT_LSB 0
`define RC_B_SWITCH_BIT 14
`define RC_B_FLOAT_BIT 10
`define RC_INT_FAULT_BIT 0
`define RC_INT_HIB_BIT 1
`define RC_INT_W 2

// ==========================================
// reset values and implemented bits
`define RC_A_SEQ_DEFAULT 16'h0000
`define RC_A_LP_DEFAULT 16'h001c
`define RC_B_CTRL_DEFAULT 16'h001b
`define RC_A_SEQ_MASK 16'hffc0
`define RC_A_LP_MASK 16'h331f
`define RC_B_CTRL_MASK 16'h441f

// ==========================================
// voltage coding in millivolts: 1800 base, 100 step; 900 base, 50 step
`define RC_MV_HIGH_BASE 12'h708
`define RC_MV_HIGH_STEP 12'h064
`define RC_MV_LOW_BASE 12'h384
`define RC_MV_LOW_STEP 12'h032

`endif

/* verilog/regulator_ctrl_pkg.sv */
// types shared by the regulator control slice
// assumes nothing beyond the defines header for values
package regulator_ctrl_pkg;

  typedef enum logic [1:0] {
    FAULT_IGNORE = 2'b00,
    FAULT_REG_OFF = 2'b01,
    FAULT_SYS_OFF = 2'b10,
    FAULT_SYS_OFF_RSV = 2'b11
  } fault_action_e;

  typedef enum logic [1:0] {
    HIB_IMAGE = 2'b00,
    HIB_DISABLE = 2'b01,
    HIB_RSV_A = 2'b10,
    HIB_RSV_B = 2'b11
  } hib_behaviour_e;

  typedef enum logic [1:0] {
    TRIG_REG_BIT = 2'b00,
    TRIG_LP_ONE = 2'b01,
    TRIG_LP_TWO = 2'b10,
    TRIG_LP_THREE = 2'b11
  } hib_trigger_e;

  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_A_SEQ = 3'h1,
    SEL_A_LP = 3'h2,
    SEL_B_CTRL = 3'h3,
    SEL_INT_STATUS = 3'h4,
    SEL_INT_CLEAR = 3'h5,
    SEL_INT_ENABLE = 3'h6,
    SEL_HIB_CTRL = 3'h7
  } reg_sel_e;

  typedef struct packed {
    logic low_power_input_one;
    logic low_power_input_two;
    logic low_power_input_three;
  } lp_inputs_s;

  typedef struct packed {
    logic start_off;
    logic start_on_active;
    logic [3:0] start_slot;
    logic stop_on_off;
    logic [3:0] stop_slot;
  } seq_slots_s;

endpackage

/* verilog/voltage_decode.sv */
// decodes a 5-bit regulator voltage code into millivolts
// assumes the caller registers the result
`timescale 1ns/1ps
`include "regulator_ctrl_defines.svh"
module voltage_decode #(
  parameter int CODE_W = 5
)(
  input wire logic [CODE_W-1:0] code,
  output logic [11:0] millivolts
);

  if (CODE_W != 5)
  begin : g_bad_width
    $error("voltage_decode serves 5-bit codes only");
  end

  // upper half in coarse steps, lower half in fine steps
  always_comb
  begin
    if (code[4])
      millivolts = 12'(`RC_MV_HIGH_BASE + 12'(code[3:0]) * `RC_MV_HIGH_STEP);
    else
      millivolts = 12'(`RC_MV_LOW_BASE + 12'(code[3:0]) * `RC_MV_LOW_STEP);
  end

endmodule

/* verilog/regulator_ctrl_regs.sv */
// register slice for regulator A sequencing and low power, and regulator B control
// assumes an APB master on pclk, an external sequencer and power state machine
//
// Operation
// - regulator A fault raises interrupt; 00 nothing, 01 regulator off, else system off
// - start-up slot: 0000 never, 0001-1110 slots 1-14, 1111 on entering active
// - shutdown slot: 0001-1110 slots 1-14; 0000 and 1111 on entering off
// - hibernate behaviour: 00 image voltage, 01 output disabled, 10/11 reserved
// - hibernate trigger: 00 register bit, 01-11 low power inputs one to three
// - image voltage: 100mV steps 3.3V to 1.8V, 50mV steps 1.65V to 0.9V
// - regulator B bit 14: 0 regulates, 1 switch ignoring voltage select
// - regulator B bit 10: 0 discharge output while disabled, 1 leave floating
// - all four regulators disabled discharges all outputs regardless of float bits
// - regulator B voltage select uses image coding, regulator mode only
// - state machine reload restores variant defaults given by parameters
`timescale 1ns/1ps
`include "regulator_ctrl_defines.svh"
module regulator_ctrl_regs #(
  parameter int ADDR_W = 12,
  parameter logic [15:0] A_SEQ_DEFAULT = `RC_A_SEQ_DEFAULT,
  parameter logic [15:0] A_LP_DEFAULT = `RC_A_LP_DEFAULT,
  parameter logic [15:0] B_CTRL_DEFAULT = `RC_B_CTRL_DEFAULT
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic psm_reload,
  input wire logic reg_a_fault,
  input regulator_ctrl_pkg::lp_inputs_s lp_in,
  input wire logic reg_a_enabled,
  input wire logic reg_b_enabled,
  input wire logic [1:0] other_disabled,
  input wire logic [4:0] reg_a_normal_vsel,
  output regulator_ctrl_pkg::seq_slots_s a_slots,
  output logic reg_a_fault_off,
  output logic system_off,
  output logic reg_a_hibernate,
  output logic reg_a_hib_disable,
  output logic [11:0] reg_a_target_mv,
  output logic reg_b_switch_mode,
  output logic reg_b_vsel_active,
  output logic [11:0] reg_b_target_mv,
  output logic reg_b_discharge,
  output logic all_discharge,
  output logic irq
);

  if (ADDR_W < 10)
  begin : g_bad_addr
    $error("regulator_ctrl_regs needs at least 10 address bits");
  end

  // ==========================================
  // decoding helpers
  function automatic regulator_ctrl_pkg::reg_sel_e decode(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] word;
    word = a >> 2;
    decode = regulator_ctrl_pkg::SEL_NONE;
    if (a[1:0] == 2'h0)
    begin
      if (word == ADDR_W'(`RC_IDX_A_SEQ))
        decode = regulator_ctrl_pkg::SEL_A_SEQ;
      else if (word == ADDR_W'(`RC_IDX_A_LP))
        decode = regulator_ctrl_pkg::SEL_A_LP;
      else if (word == ADDR_W'(`RC_IDX_B_CTRL))
        decode = regulator_ctrl_pkg::SEL_B_CTRL;
      else if (word == ADDR_W'(`RC_IDX_INT_STATUS))
        decode = regulator_ctrl_pkg::SEL_INT_STATUS;
      else if (word == ADDR_W'(`RC_IDX_INT_CLEAR))
        decode = regulator_ctrl_pkg::SEL_INT_CLEAR;
      else if (word == ADDR_W'(`RC_IDX_INT_ENABLE))
        decode = regulator_ctrl_pkg::SEL_INT_ENABLE;
      else if (word == ADDR_W'(`RC_IDX_HIB_CTRL))
        decode = regulator_ctrl_pkg::SEL_HIB_CTRL;
    end
  endfunction

  // merges the two low byte lanes; unimplemented bits stay zero
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] m;
    m = old;
    if (strb[0])
      m[7:0] = wd[7:0];
    if (strb[1])
      m[15:8] = wd[15:8];
    merge16 = m & mask;
  endfunction

  function automatic regulator_ctrl_pkg::seq_slots_s decode_slots(input logic [15:0] r);
    regulator_ctrl_pkg::seq_slots_s s;
    logic [3:0] st;
    logic [3:0] sd;
    st = r[`RC_A_START_MSB:`RC_A_START_LSB];
    sd = r[`RC_A_STOP_MSB:`RC_A_STOP_LSB];
    s.start_off = (st == 4'h0);
    s.start_on_active = (st == 4'hf);
    s.start_slot = (st == 4'h0 || st == 4'hf) ? 4'h0 : st;
    s.stop_on_off = (sd == 4'h0 || sd == 4'hf);
    s.stop_slot = (sd == 4'h0 || sd == 4'hf) ? 4'h0 : sd;
    decode_slots = s;
  endfunction

  // ==========================================
  // register state
  logic [15:0] a_seq;
  logic [15:0] next_a_seq;
  logic [15:0] a_lp;
  logic [15:0] next_a_lp;
  logic [15:0] b_ctrl;
  logic [15:0] next_b_ctrl;
  logic [`RC_INT_W-1:0] int_status;
  logic [`RC_INT_W-1:0] next_int_status;
  logic [`RC_INT_W-1:0] int_enable;
  logic [`RC_INT_W-1:0] next_int_enable;
  logic hib_bit;
  logic next_hib_bit;
  logic [31:0] next_prdata;
  logic [`RC_INT_W-1:0] events;
  regulator_ctrl_pkg::reg_sel_e sel;
  logic wr_access;
  logic [15:0] out_status;

  assign sel = decode(paddr);
  assign wr_access = psel && penable && pwrite;
  // zero wait states keeps the master simple; read data is staged in setup
  assign pready = 1'b1;
  assign pslverr = psel && penable && (sel == regulator_ctrl_pkg::SEL_NONE)
                   && !(paddr[1:0] == 2'h0 && (paddr >> 2) == ADDR_W'(`RC_IDX_OUT_STATUS));
  assign out_status = {11'h000, reg_a_fault, all_discharge, reg_b_discharge,
                       reg_a_hib_disable, reg_a_hibernate};

  always_comb
  begin
    next_a_seq = a_seq;
    next_a_lp = a_lp;
    next_b_ctrl = b_ctrl;
    next_int_enable = int_enable;
    next_hib_bit = hib_bit;
    next_int_status = int_status;
    next_prdata = prdata;
    if (wr_access)
    begin
      unique case (sel)
        regulator_ctrl_pkg::SEL_A_SEQ:
          next_a_seq = merge16(a_seq, pwdata, pstrb, `RC_A_SEQ_MASK);
        regulator_ctrl_pkg::SEL_A_LP:
          next_a_lp = merge16(a_lp, pwdata, pstrb, `RC_A_LP_MASK);
        regulator_ctrl_pkg::SEL_B_CTRL:
          next_b_ctrl = merge16(b_ctrl, pwdata, pstrb, `RC_B_CTRL_MASK);
        regulator_ctrl_pkg::SEL_INT_CLEAR:
          if (pstrb[0])
            next_int_status = int_status & ~pwdata[`RC_INT_W-1:0];
        regulator_ctrl_pkg::SEL_INT_ENABLE:
          if (pstrb[0])
            next_int_enable = pwdata[`RC_INT_W-1:0];
        regulator_ctrl_pkg::SEL_HIB_CTRL:
          if (pstrb[0])
            next_hib_bit = pwdata[0];
        regulator_ctrl_pkg::SEL_INT_STATUS, regulator_ctrl_pkg::SEL_NONE:
          next_hib_bit = hib_bit;
      endcase
    end
    // a set arriving with its clear is kept
    next_int_status = next_int_status | events;
    // the state machine outranks a concurrent software write
    if (psm_reload)
    begin
      next_a_seq = A_SEQ_DEFAULT & `RC_A_SEQ_MASK;
      next_a_lp = A_LP_DEFAULT & `RC_A_LP_MASK;
      next_b_ctrl = B_CTRL_DEFAULT & `RC_B_CTRL_MASK;
    end
    if (psel && !penable && !pwrite)
    begin
      unique case (sel)
        regulator_ctrl_pkg::SEL_A_SEQ: next_prdata = {16'h0000, a_seq};
        regulator_ctrl_pkg::SEL_A_LP: next_prdata = {16'h0000, a_lp};
        regulator_ctrl_pkg::SEL_B_CTRL: next_prdata = {16'h0000, b_ctrl};
        regulator_ctrl_pkg::SEL_INT_STATUS: next_prdata = {30'h0, int_status};
        regulator_ctrl_pkg::SEL_INT_ENABLE: next_prdata = {30'h0, int_enable};
        regulator_ctrl_pkg::SEL_HIB_CTRL: next_prdata = {31'h0, hib_bit};
        regulator_ctrl_pkg::SEL_INT_CLEAR: next_prdata = 32'h0;
        regulator_ctrl_pkg::SEL_NONE: next_prdata = {16'h0000, out_status};
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      a_seq <= `RC_A_SEQ_DEFAULT;
      a_lp <= `RC_A_LP_DEFAULT;
      b_ctrl <= `RC_B_CTRL_DEFAULT;
      int_status <= 2'h0;
      int_enable <= 2'h0;
      hib_bit <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      a_seq <= next_a_seq;
      a_lp <= next_a_lp;
      b_ctrl <= next_b_ctrl;
      int_status <= next_int_status;
      int_enable <= next_int_enable;
      hib_bit <= next_hib_bit;
      prdata <= next_prdata;
    end
  end

  assign irq = |(int_status & int_enable);

  // ==========================================
  // regulator control outputs
  regulator_ctrl_pkg::fault_action_e action;
  regulator_ctrl_pkg::hib_behaviour_e behaviour;
  regulator_ctrl_pkg::hib_trigger_e trigger;
  logic fault_q;
  logic hib_sel;
  logic all_off;
  logic [4:0] a_code;
  logic [11:0] a_mv;
  logic [11:0] b_mv;
  regulator_ctrl_pkg::seq_slots_s next_a_slots;
  logic next_fault_off;
  logic next_system_off;
  logic next_hib_disable;
  logic [11:0] next_a_target;
  logic [11:0] next_b_target;
  logic next_b_discharge;

  assign action = regulator_ctrl_pkg::fault_action_e'(a_seq[`RC_A_FAULT_MSB:`RC_A_FAULT_LSB]);
  assign behaviour =
    regulator_ctrl_pkg::hib_behaviour_e'(a_lp[`RC_A_HIB_BEH_MSB:`RC_A_HIB_BEH_LSB]);
  assign trigger =
    regulator_ctrl_pkg::hib_trigger_e'(a_lp[`RC_A_HIB_TRIG_MSB:`RC_A_HIB_TRIG_LSB]);

  voltage_decode #(.CODE_W(5)) u_a_volt (.code(a_code), .millivolts(a_mv));
  voltage_decode #(.CODE_W(5)) u_b_volt (.code(b_ctrl[`RC_VOLT_MSB:`RC_VOLT_LSB]),
                                         .millivolts(b_mv));

  always_comb
  begin
    unique case (trigger)
      regulator_ctrl_pkg::TRIG_REG_BIT: hib_sel = hib_bit;
      regulator_ctrl_pkg::TRIG_LP_ONE: hib_sel = lp_in.low_power_input_one;
      regulator_ctrl_pkg::TRIG_LP_TWO: hib_sel = lp_in.low_power_input_two;
      regulator_ctrl_pkg::TRIG_LP_THREE: hib_sel = lp_in.low_power_input_three;
    endcase
    events = {hib_sel && !reg_a_hibernate, reg_a_fault && !fault_q};
    next_fault_off = events[`RC_INT_FAULT_BIT]
                     && (action == regulator_ctrl_pkg::FAULT_REG_OFF);
    // reserved code 11 behaves as system shutdown
    next_system_off = events[`RC_INT_FAULT_BIT] && action[1];
    next_a_slots = decode_slots(a_seq);
    // reserved behaviours leave the regulator on its normal setting
    next_hib_disable = hib_sel && (behaviour == regulator_ctrl_pkg::HIB_DISABLE);
    a_code = (hib_sel && behaviour == regulator_ctrl_pkg::HIB_IMAGE)
             ? a_lp[`RC_VOLT_MSB:`RC_VOLT_LSB] : reg_a_normal_vsel;
    next_a_target = a_mv;
    next_b_target = b_ctrl[`RC_B_SWITCH_BIT] ? 12'h000 : b_mv;
    all_off = !reg_a_enabled && !reg_b_enabled && (&other_disabled);
    next_b_discharge = !reg_b_enabled && (!b_ctrl[`RC_B_FLOAT_BIT] || all_off);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fault_q <= 1'b0;
      a_slots <= '0;
      reg_a_fault_off <= 1'b0;
      system_off <= 1'b0;
      reg_a_hibernate <= 1'b0;
      reg_a_hib_disable <= 1'b0;
      reg_a_target_mv <= 12'h000;
      reg_b_switch_mode <= 1'b0;
      reg_b_vsel_active <= 1'b0;
      reg_b_target_mv <= 12'h000;
      reg_b_discharge <= 1'b0;
      all_discharge <= 1'b0;
    end
    else
    begin
      fault_q <= reg_a_fault;
      a_slots <= next_a_slots;
      reg_a_fault_off <= next_fault_off;
      system_off <= next_system_off;
      reg_a_hibernate <= hib_sel;
      reg_a_hib_disable <= next_hib_disable;
      reg_a_target_mv <= next_a_target;
      reg_b_switch_mode <= b_ctrl[`RC_B_SWITCH_BIT];
      reg_b_vsel_active <= !b_ctrl[`RC_B_SWITCH_BIT];
      reg_b_target_mv <= next_b_target;
      reg_b_discharge <= next_b_discharge;
      all_discharge <= all_off;
    end
  end

  // ==========================================
  // checks
  property p_fault_reg_off;
    @(posedge pclk) disable iff (!presetn)
    (reg_a_fault && !fault_q && action == regulator_ctrl_pkg::FAULT_REG_OFF)
    |=> (reg_a_fault_off && !system_off && int_status[0]) ##1 !reg_a_fault_off;
  endproperty
  a_fault_reg_off: assert property (p_fault_reg_off) else $error("fault action 01 wrong");

  property p_fault_sys_off;
    @(posedge pclk) disable iff (!presetn)
    $rose(reg_a_fault) && a_seq[15] |=> system_off && !reg_a_fault_off;
  endproperty
  a_fault_sys_off: assert property (p_fault_sys_off) else $error("system shutdown missed");

  property p_start_slot;
    @(posedge pclk) disable iff (!presetn)
    a_seq[13:10] == 4'hf |=> a_slots.start_on_active && !a_slots.start_off;
  endproperty
  a_start_slot: assert property (p_start_slot) else $error("start on active wrong");

  property p_stop_slot;
    @(posedge pclk) disable iff (!presetn)
    a_seq[9:6] == 4'h0 |=> a_slots.stop_on_off && a_slots.stop_slot == 4'h0;
  endproperty
  a_stop_slot: assert property (p_stop_slot) else $error("shutdown on off wrong");

  property p_hib_disable;
    @(posedge pclk) disable iff (!presetn)
    a_lp[13:8] == 6'h11 && lp_in.low_power_input_one |=> reg_a_hib_disable && reg_a_hibernate;
  endproperty
  a_hib_disable: assert property (p_hib_disable) else $error("hibernate disable missed");

  property p_hib_reg_bit;
    @(posedge pclk) disable iff (!presetn)
    a_lp[9:8] == 2'h0 |=> reg_a_hibernate == $past(hib_bit);
  endproperty
  a_hib_reg_bit: assert property (p_hib_reg_bit) else $error("hibernate trigger wrong");

  property p_image_volt;
    @(posedge pclk) disable iff (!presetn)
    a_lp[13:8] == 6'h00 && hib_bit && a_lp[4:0] == 5'h0f |=> reg_a_target_mv == 12'h672;
  endproperty
  a_image_volt: assert property (p_image_volt) else $error("image voltage not applied");

  property p_switch_mode;
    @(posedge pclk) disable iff (!presetn)
    b_ctrl[14] |=> !reg_b_vsel_active && reg_b_switch_mode && reg_b_target_mv == 12'h000;
  endproperty
  a_switch_mode: assert property (p_switch_mode) else $error("switch mode wrong");

  property p_b_volt;
    @(posedge pclk) disable iff (!presetn)
    !b_ctrl[14] && b_ctrl[4:0] == 5'h10 |=> reg_b_target_mv == 12'h708;
  endproperty
  a_b_volt: assert property (p_b_volt) else $error("regulator B voltage wrong");

  property p_discharge;
    @(posedge pclk) disable iff (!presetn)
    !reg_b_enabled && (!b_ctrl[10] || (!reg_a_enabled && &other_disabled))
    |=> reg_b_discharge;
  endproperty
  a_discharge: assert property (p_discharge) else $error("discharge missed");

  property p_float;
    @(posedge pclk) disable iff (!presetn)
    b_ctrl[10] && reg_a_enabled |=> !reg_b_discharge && !all_discharge;
  endproperty
  a_float: assert property (p_float) else $error("float not honoured");

  property p_reload;
    @(posedge pclk) disable iff (!presetn)
    psm_reload |=> a_seq == (A_SEQ_DEFAULT & 16'hffc0) && b_ctrl == (B_CTRL_DEFAULT & 16'h441f);
  endproperty
  a_reload: assert property (p_reload) else $error("reload skipped");

endmodule

/* dv/tb_top.sv */
// self-checking bench for the regulator register slice
// assumes the design package and defines header are compiled first
`timescale 1ns/1ps
`include "regulator_ctrl_defines.svh"
module tb_top;
  // arbitrary variant defaults, distinct from the compile defaults
  localparam logic [15:0] P_A_SEQ = 16'h4c40;
  localparam logic [15:0] P_A_LP = 16'h1115;
  localparam logic [15:0] P_B = 16'h041a;
  typedef struct packed {logic [43:0] val; logic [43:0] mask;} note_s;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [3:0] pstrb = 0;
  logic pready, pslverr, psm_reload = 0, reg_a_fault = 0;
  logic reg_a_enabled = 1, reg_b_enabled = 1, probe_q = 0;
  logic [2:0] lp_in = 0;
  logic [1:0] other_disabled = 0, status = 0, enable = 0;
  logic [4:0] reg_a_normal_vsel = 0;
  logic [10:0] a_slots;
  logic reg_a_fault_off, system_off, reg_a_hibernate, reg_a_hib_disable, reg_b_switch_mode;
  logic reg_b_vsel_active, reg_b_discharge, all_discharge, irq, hib_bit = 0, hib_prev = 0;
  logic [11:0] reg_a_target_mv, reg_b_target_mv;
  logic [15:0] a_seq = `RC_A_SEQ_DEFAULT, a_lp = `RC_A_LP_DEFAULT, b_ctrl = `RC_B_CTRL_DEFAULT;
  logic [31:0] v;
  int seed = 21, n_mismatch = 0, checked = 0, cycles = 0;
  note_s notes[$];
  wire logic [43:0] obs = {reg_a_target_mv, reg_b_target_mv, reg_a_fault_off, system_off,
    reg_a_hibernate, reg_a_hib_disable, reg_b_switch_mode, reg_b_vsel_active, reg_b_discharge,
    all_discharge, irq, a_slots};

  regulator_ctrl_regs #(.ADDR_W(12), .A_SEQ_DEFAULT(P_A_SEQ), .A_LP_DEFAULT(P_A_LP),
    .B_CTRL_DEFAULT(P_B)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .psm_reload(psm_reload),
    .reg_a_fault(reg_a_fault), .lp_in(lp_in), .reg_a_enabled(reg_a_enabled),
    .reg_b_enabled(reg_b_enabled), .other_disabled(other_disabled),
    .reg_a_normal_vsel(reg_a_normal_vsel), .a_slots(a_slots), .reg_a_fault_off(reg_a_fault_off),
    .system_off(system_off), .reg_a_hibernate(reg_a_hibernate),
    .reg_a_hib_disable(reg_a_hib_disable), .reg_a_target_mv(reg_a_target_mv),
    .reg_b_switch_mode(reg_b_switch_mode), .reg_b_vsel_active(reg_b_vsel_active),
    .reg_b_target_mv(reg_b_target_mv), .reg_b_discharge(reg_b_discharge),
    .all_discharge(all_discharge), .irq(irq));

  always #50 pclk = ~pclk;

  // ==========================================
  // model helpers
  function automatic logic [11:0] mv(input logic [4:0] c);
    int x;
    x = c;
    return (x >= 16) ? 12'(1800 + (x - 16) * 100) : 12'(900 + x * 50);
  endfunction

  function automatic logic hib_now();
    return (a_lp[9:8] == 2'b00) ? hib_bit : lp_in[3 - int'(a_lp[9:8])];
  endfunction

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================
  // drivers: each APB access and each probe pushes the note that the monitor consumes
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
    input logic [3:0] s, input logic [43:0] val, input logic [43:0] mask);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    notes.push_back({val, mask});
    @(posedge pclk);
    // no local limit: only the bench timeout ends a wait
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 0;
    penable <= 0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s);
    logic [15:0] m;
    logic ok;
    m = {{8{s[1]}}, {8{s[0]}}};
    ok = 1;
    case (idx)
      `RC_IDX_A_SEQ: a_seq = (a_seq & ~m) | (d[15:0] & m & `RC_A_SEQ_MASK);
      `RC_IDX_A_LP: a_lp = (a_lp & ~m) | (d[15:0] & m & `RC_A_LP_MASK);
      `RC_IDX_B_CTRL: b_ctrl = (b_ctrl & ~m) | (d[15:0] & m & `RC_B_CTRL_MASK);
      `RC_IDX_INT_CLEAR: if (s[0]) status = status & ~d[1:0];
      `RC_IDX_INT_ENABLE: if (s[0]) enable = d[1:0];
      `RC_IDX_HIB_CTRL: if (s[0]) hib_bit = d[0];
      `RC_IDX_INT_STATUS, `RC_IDX_OUT_STATUS: ok = 1;
      default: ok = 0;
    endcase
    apb(1, idx, d, s, {11'h0, !ok, 32'h0}, {11'h0, 1'b1, 32'h0});
  endtask

  task automatic rd(input logic [7:0] idx);
    logic [31:0] e, m;
    logic ok;
    ok = 1;
    m = 32'hffffffff;
    e = 32'h0;
    case (idx)
      `RC_IDX_A_SEQ: e = {16'h0, a_seq};
      `RC_IDX_A_LP: e = {16'h0, a_lp};
      `RC_IDX_B_CTRL: e = {16'h0, b_ctrl};
      `RC_IDX_INT_STATUS: e = {30'h0, status};
      `RC_IDX_INT_CLEAR: e = 32'h0;
      `RC_IDX_INT_ENABLE: e = {30'h0, enable};
      `RC_IDX_HIB_CTRL: e = {31'h0, hib_bit};
      `RC_IDX_OUT_STATUS: m = 32'h0;
      default:
      begin
        ok = 0;
        m = 32'h0;
      end
    endcase
    apb(0, idx, 32'h0, 4'h0, {11'h0, !ok, e}, {11'h0, 1'b1, m});
  endtask

  // outputs register one edge after a change; fault pulses stand for that one cycle only
  task automatic probe(input logic fo, input logic so);
    logic hib, alld;
    logic [3:0] st, sp;
    logic [43:0] e, m;
    @(posedge pclk);
    hib = hib_now();
    if (hib && !hib_prev) status[1] = 1'b1;
    hib_prev = hib;
    alld = !reg_a_enabled && !reg_b_enabled && (&other_disabled);
    st = a_seq[13:10];
    sp = a_seq[9:6];
    e[43:32] = (hib && a_lp[13:12] == 2'b00) ? mv(a_lp[4:0]) : mv(reg_a_normal_vsel);
    e[31:20] = b_ctrl[14] ? 12'h000 : mv(b_ctrl[4:0]);
    e[19:11] = {fo, so, hib, hib && a_lp[13:12] == 2'b01, b_ctrl[14], !b_ctrl[14],
      !reg_b_enabled && (!b_ctrl[10] || alld), alld, |(status & enable)};
    e[10:0] = {st == 4'h0, st == 4'hf, (st == 4'h0 || st == 4'hf) ? 4'h0 : st,
      sp == 4'h0 || sp == 4'hf, (sp == 4'h0 || sp == 4'hf) ? 4'h0 : sp};
    m = '1;
    notes.push_back({e, m});
    probe_q <= 1;
    @(posedge pclk);
    probe_q <= 0;
  endtask

  task automatic src(input int t, input logic val);
    if (t == 0)
      wr(`RC_IDX_HIB_CTRL, {31'h0, val}, 4'h1);
    else
    begin
      @(posedge pclk);
      lp_in[3 - t] <= val;
      v = $random(seed);
      reg_a_normal_vsel <= v[4:0];
    end
  endtask

  // ==========================================
  // monitor
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      final_report();
    end
  end

  always @(posedge pclk)
  begin
    note_s n;
    logic [43:0] act;
    if (presetn && ((psel && penable && pready) || probe_q))
    begin
      act = (psel && penable) ? {11'h0, pslverr, prdata} : obs;
      checked++;
      if (notes.size() == 0)
      begin
        n_mismatch++;
        $display("CHECK FAILED at %0t: result with no expectation", $time);
      end
      else
      begin
        n = notes.pop_front();
        if ((act & n.mask) !== (n.val & n.mask))
        begin
          n_mismatch++;
          $display("CHECK FAILED at %0t: expected %h got %h", $time, n.val & n.mask, act);
        end
      end
    end
  end

  // ==========================================
  // main sequence
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    rd(`RC_IDX_A_SEQ);
    rd(`RC_IDX_A_LP);
    rd(`RC_IDX_B_CTRL);
    probe(0, 0);
    wr(`RC_IDX_B_CTRL, 32'hffffffff, 4'h3);
    rd(`RC_IDX_B_CTRL);
    wr(`RC_IDX_B_CTRL, 32'h0, 4'h2);
    rd(`RC_IDX_B_CTRL);
    wr(8'h10, 32'h5, 4'h3);
    rd(8'h10);
    wr(`RC_IDX_INT_STATUS, 32'h3, 4'h1);
    rd(`RC_IDX_INT_CLEAR);
    for (int i = 0; i < 16; i++)
    begin
      wr(`RC_IDX_A_SEQ, {16'h0, 2'b00, 4'(i), 4'(15 - i), 6'h0}, 4'h3);
      probe(0, 0);
    end
    wr(`RC_IDX_INT_ENABLE, 32'h1, 4'h1);
    for (int i = 0; i < 4; i++)
    begin
      wr(`RC_IDX_A_SEQ, {16'h0, 2'(i), 14'h0}, 4'h3);
      @(posedge pclk);
      reg_a_fault <= 1;
      status[0] = 1'b1;
      probe(i == 1, i >= 2);
      reg_a_fault <= 0;
      probe(0, 0);
      rd(`RC_IDX_INT_STATUS);
      wr(`RC_IDX_INT_CLEAR, 32'h1, 4'h1);
      probe(0, 0);
    end
    for (int i = 0; i < 16; i++)
    begin
      v = $random(seed);
      // pins one known image code so the fine-step decode is seen under hibernate
      if (i == 0) v[4:0] = 5'h0f;
      wr(`RC_IDX_A_LP, {16'h0, 2'b00, 2'(i), 2'b00, 2'(i >> 2), 3'h0, v[4:0]}, 4'h3);
      src(i >> 2, 1);
      probe(0, 0);
      src(i >> 2, 0);
      probe(0, 0);
    end
    rd(`RC_IDX_INT_STATUS);
    wr(`RC_IDX_INT_CLEAR, 32'h3, 4'h1);
    for (int i = 0; i < 24; i++)
    begin
      v = $random(seed);
      if (i % 4 == 0) v[10:7] = 4'b1100;
      // regulator mode at the coarse-step boundary code
      if (i == 1) v[6:0] = 7'h10;
      wr(`RC_IDX_B_CTRL, {16'h0, 1'b0, v[6], 3'h0, v[5], 5'h0, v[4:0]}, 4'h3);
      @(posedge pclk);
      reg_a_enabled <= v[7];
      reg_b_enabled <= v[8];
      other_disabled <= v[10:9];
      probe(0, 0);
    end
    @(posedge pclk);
    psm_reload <= 1;
    @(posedge pclk);
    psm_reload <= 0;
    a_seq = P_A_SEQ;
    a_lp = P_A_LP;
    b_ctrl = P_B;
    probe(0, 0);
    rd(`RC_IDX_A_SEQ);
    rd(`RC_IDX_A_LP);
    rd(`RC_IDX_B_CTRL);
    repeat (3) @(posedge pclk);
    if (notes.size() != 0) n_mismatch++;
    final_report();
  end
endmodule
